// file: common/pmn_defs.svh
`ifndef PMN_DEFS_SVH
`define PMN_DEFS_SVH

// system clock period
`define PMN_CLK_NS          50
// strap sampling window after reset release
`define PMN_STRAP_TIME_NS   1000
`define PMN_STRAP_CYCLES    ((`PMN_STRAP_TIME_NS + `PMN_CLK_NS - 1) / `PMN_CLK_NS)
// reference edges per half period of the mii clock in 10 mb/s mode
`define PMN_DIV10_EDGES     4'd10
// fixed address bit
`define PMN_ADDR2_VALUE     1'b0
// led function select code that picks the pin default
`define PMN_LED_SEL_DEFAULT 2'h0

`endif

// file: common/pmn_pkg.sv
`default_nettype none
package pmn_pkg;

    typedef enum logic [1:0] {
        pmn_led_activity,
        pmn_led_speed,
        pmn_led_link,
        pmn_led_off
    } pmn_led_func_t;

    typedef enum logic {
        pmn_st_strap,
        pmn_st_run
    } pmn_phase_t;

endpackage : pmn_pkg
`default_nettype wire

// file: logic/pmn_led_strap_pin.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmn_defs.svh"

module pmn_led_strap_pin #(
    parameter pmn_pkg::pmn_led_func_t DEFAULT_FUNC = pmn_pkg::pmn_led_activity
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       pin_in,
    input  wire logic       run_in,
    input  wire logic [1:0] func_sel_in,
    input  wire logic       input_role_in,
    input  wire logic       activity_in,
    input  wire logic       speed100_in,
    input  wire logic       link_in,
    output logic            pin_out,
    output logic            pin_oe_out,
    output logic            level_out
);
    import pmn_pkg::*;

    logic [2:0]    sync_q;
    logic [2:0]    sync_d;
    logic          level_d;
    logic          led_d;
    logic          oe_d;
    pmn_led_func_t func;

    always_comb begin
        sync_d = {sync_q[1:0], pin_in};
        // accept a change only once stages two and three agree
        level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_out;
        if (func_sel_in == `PMN_LED_SEL_DEFAULT) begin
            func = DEFAULT_FUNC;
        end else begin
            func = pmn_led_func_t'(func_sel_in);
        end
        case (func)
            pmn_led_activity: led_d = activity_in;
            pmn_led_speed:    led_d = speed100_in;
            pmn_led_link:     led_d = link_in;
            default:          led_d = 1'b0;
        endcase
        // pin stays an input while straps are read or when it acts as isolate input
        oe_d = run_in & ~input_role_in;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_q     <= 3'h0;
            level_out  <= 1'b0;
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            sync_q     <= sync_d;
            level_out  <= level_d;
            pin_out    <= led_d & oe_d;
            pin_oe_out <= oe_d;
        end
    end

endmodule : pmn_led_strap_pin

`default_nettype wire

// file: logic/pmn_mii_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmn_defs.svh"

// Function
// - while transmit enable is high, one nibble per transmit clock is accepted.
// - with transmit enable low, transmit data has no effect at all.
// - receive nibble is driven synchronous with our receive clock output.
// - receive valid is high exactly while receive nibble carries data.
// - first dual-use pin is sampled at reset as address bit 0.
// - after reset first dual-use pin is led 0, default activity.
// - second dual-use pin is sampled at reset as address bit 1.
// - after reset second dual-use pin is led 1, default speed.
// - second dual-use pin may act as live receive isolation input.
// - mii clock and crystal drive derive from the reference clock input; strap window counts clk_in cycles.
// - address is four latched bits, bit 2 fixed at zero.
// - isolate role only when isolation strap latched high; led then off.
module pmn_mii_port #(
    parameter int STRAP_CYCLES = `PMN_STRAP_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       reference_clock_input_in,
    input  wire logic       crystal_mode_in,
    output logic            crystal_drive_output_out,
    output logic            crystal_drive_output_oe_out,
    input  wire logic       speed100_in,
    input  wire logic       link_up_in,
    output logic            tx_clk_out,
    input  wire logic       tx_en_in,
    input  wire logic [3:0] txd_in,
    output logic [3:0]      tx_nibble_out,
    output logic            tx_nibble_valid_out,
    output logic            rx_clk_out,
    output logic [3:0]      rxd_out,
    output logic            rx_dv_out,
    output logic            rx_oe_out,
    input  wire logic [3:0] rx_nibble_in,
    input  wire logic       rx_valid_in,
    output logic            rx_take_out,
    input  wire logic       receive_isolation_strap_in,
    input  wire logic       addr3_strap_in,
    output logic [3:0]      phy_addr_out,
    output logic            strap_done_out,
    output logic            isolate_active_out,
    input  wire logic [1:0] led0_func_in,
    input  wire logic [1:0] led1_func_in,
    input  wire logic       addr0_led0_pin_in,
    output logic            addr0_led0_pin_out,
    output logic            addr0_led0_pin_oe_out,
    input  wire logic       addr1_isolate_led1_pin_in,
    output logic            addr1_isolate_led1_pin_out,
    output logic            addr1_isolate_led1_pin_oe_out
);
    import pmn_pkg::*;

    localparam int SW = 8;
    localparam logic [15:0] STRAP_LAST = 16'(STRAP_CYCLES - 1);

    // sync layout: ref, tx_en, txd[3:0], iso strap, addr3 strap
    logic [SW-1:0] s1_q, s2_q, s3_q, f_q;
    logic [SW-1:0] s1_d, s2_d, s3_d, f_d;
    logic          ref_old_q, ref_old_d;
    pmn_phase_t    phase_q, phase_d;
    logic [15:0]   cnt_q, cnt_d;
    logic [3:0]    edge_q, edge_d;
    logic          mclk_q, mclk_d;
    logic [3:0]    txn_q, txn_d;
    logic          txv_q, txv_d;
    logic [3:0]    rxd_q, rxd_d;
    logic          rxdv_q, rxdv_d;
    logic          rxoe_q, rxoe_d;
    logic          take_q, take_d;
    logic [3:0]    addr_q, addr_d;
    logic          iso_en_q, iso_en_d;
    logic          iso_q, iso_d;
    logic          xtal_q, xtal_d;
    logic          xtal_oe_q, xtal_oe_d;
    logic          p0_level, p1_level;
    logic          run;
    logic          ref_edge;
    logic          mclk_rise, mclk_fall;
    logic          activity;

    function automatic logic [SW-1:0] agree(input logic [SW-1:0] a, input logic [SW-1:0] b,
                                            input logic [SW-1:0] keep);
        agree = (a & b) | (keep & (a | b));
    endfunction : agree

    assign run      = (phase_q == pmn_st_run);
    assign activity = f_q[6] | rxdv_q;

    always_comb begin
        s1_d = {reference_clock_input_in, tx_en_in, txd_in,
                receive_isolation_strap_in, addr3_strap_in};
        s2_d = s1_q;
        s3_d = s2_q;
        // bit changes only where stages two and three agree
        f_d       = agree(s2_q, s3_q, f_q);
        ref_old_d = f_q[7];
    end

    always_comb begin
        phase_d  = phase_q;
        cnt_d    = cnt_q;
        addr_d   = addr_q;
        iso_en_d = iso_en_q;
        case (phase_q)
            pmn_st_strap: begin
                // pins float as inputs for the whole window so pulls settle
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q >= STRAP_LAST) begin
                    phase_d = pmn_st_run;
                    addr_d[0] = p0_level;
                    addr_d[1] = p1_level;
                    addr_d[2] = `PMN_ADDR2_VALUE;
                    addr_d[3] = f_q[0];
                    iso_en_d = f_q[1];
                end
            end
            pmn_st_run: begin
                cnt_d = cnt_q;
            end
            default: begin
                phase_d = pmn_st_strap;
            end
        endcase
    end

    always_comb begin
        ref_edge = (f_q[7] != ref_old_q);
        edge_d   = edge_q;
        mclk_d   = mclk_q;
        // mii clock advances only on reference edges
        if (run && ref_edge) begin
            // toggle every edge at 100, every tenth edge at 10
            if (speed100_in) begin
                mclk_d = ~mclk_q;
                edge_d = 4'h0;
            end else if (edge_q >= `PMN_DIV10_EDGES - 4'd1) begin
                mclk_d = ~mclk_q;
                edge_d = 4'h0;
            end else begin
                edge_d = edge_q + 4'h1;
            end
        end
        mclk_rise = ~mclk_q & mclk_d;
        mclk_fall = mclk_q & ~mclk_d;
        // a crystal needs drive; with an oscillator the output floats
        xtal_d    = ~f_q[7];
        xtal_oe_d = crystal_mode_in;
    end

    always_comb begin
        txn_d = txn_q;
        txv_d = 1'b0;
        // sample on our rising edge, mac changed after the previous one
        if (mclk_rise) begin
            txv_d = f_q[6];
            // data blanked when enable is low
            txn_d = f_q[6] ? f_q[5:2] : 4'h0;
        end
    end

    always_comb begin
        rxd_d  = rxd_q;
        rxdv_d = rxdv_q;
        take_d = 1'b0;
        // live isolate input sampled through its synchroniser
        iso_d  = iso_en_q & p1_level;
        rxoe_d = run & ~iso_q;
        // update on falling edge so mac sees stable data at its rise
        if (mclk_fall) begin
            take_d = rx_valid_in;
            // valid tracks nibble; isolation drops the data
            rxdv_d = rx_valid_in & ~iso_q;
            rxd_d  = (rx_valid_in & ~iso_q) ? rx_nibble_in : 4'h0;
        end
        if (!run) begin
            rxdv_d = 1'b0;
            rxd_d  = 4'h0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_q      <= '0;
            s2_q      <= '0;
            s3_q      <= '0;
            f_q       <= '0;
            ref_old_q <= 1'b0;
            phase_q   <= pmn_st_strap;
            cnt_q     <= 16'h0000;
            addr_q    <= 4'h0;
            iso_en_q  <= 1'b0;
            edge_q    <= 4'h0;
            mclk_q    <= 1'b0;
            txn_q     <= 4'h0;
            txv_q     <= 1'b0;
            rxd_q     <= 4'h0;
            rxdv_q    <= 1'b0;
            rxoe_q    <= 1'b0;
            take_q    <= 1'b0;
            iso_q     <= 1'b0;
            xtal_q    <= 1'b0;
            xtal_oe_q <= 1'b0;
        end else begin
            s1_q      <= s1_d;
            s2_q      <= s2_d;
            s3_q      <= s3_d;
            f_q       <= f_d;
            ref_old_q <= ref_old_d;
            phase_q   <= phase_d;
            cnt_q     <= cnt_d;
            addr_q    <= addr_d;
            iso_en_q  <= iso_en_d;
            edge_q    <= edge_d;
            mclk_q    <= mclk_d;
            txn_q     <= txn_d;
            txv_q     <= txv_d;
            rxd_q     <= rxd_d;
            rxdv_q    <= rxdv_d;
            rxoe_q    <= rxoe_d;
            take_q    <= take_d;
            iso_q     <= iso_d;
            xtal_q    <= xtal_d;
            xtal_oe_q <= xtal_oe_d;
        end
    end

    assign tx_clk_out                  = mclk_q;
    assign rx_clk_out                  = mclk_q;
    assign tx_nibble_out               = txn_q;
    assign tx_nibble_valid_out         = txv_q;
    assign rxd_out                     = rxd_q;
    assign rx_dv_out                   = rxdv_q;
    assign rx_oe_out                   = rxoe_q;
    assign rx_take_out                 = take_q;
    assign phy_addr_out                = addr_q;
    assign strap_done_out              = phase_q == pmn_st_run;
    assign isolate_active_out          = iso_q;
    assign crystal_drive_output_out    = xtal_q;
    assign crystal_drive_output_oe_out = xtal_oe_q;

    pmn_led_strap_pin #(
        .DEFAULT_FUNC (pmn_led_activity)
    ) u_pin0 (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .pin_in        (addr0_led0_pin_in),
        .run_in        (run),
        .func_sel_in   (led0_func_in),
        .input_role_in (1'b0),
        .activity_in   (activity),
        .speed100_in   (speed100_in),
        .link_in       (link_up_in),
        .pin_out       (addr0_led0_pin_out),
        .pin_oe_out    (addr0_led0_pin_oe_out),
        .level_out     (p0_level)
    );

    // isolate role disables the led drive
    pmn_led_strap_pin #(
        .DEFAULT_FUNC (pmn_led_speed)
    ) u_pin1 (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .pin_in        (addr1_isolate_led1_pin_in),
        .run_in        (run),
        .func_sel_in   (led1_func_in),
        .input_role_in (iso_en_q),
        .activity_in   (activity),
        .speed100_in   (speed100_in),
        .link_in       (link_up_in),
        .pin_out       (addr1_isolate_led1_pin_out),
        .pin_oe_out    (addr1_isolate_led1_pin_oe_out),
        .level_out     (p1_level)
    );

endmodule : pmn_mii_port

`default_nettype wire

// file: testbench/pmn_mii_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmn_mii_port_props (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       tx_clk_out,
    input wire logic [3:0] tx_nibble_out,
    input wire logic       tx_nibble_valid_out,
    input wire logic       rx_clk_out,
    input wire logic [3:0] rxd_out,
    input wire logic       rx_dv_out,
    input wire logic       rx_oe_out,
    input wire logic       rx_take_out,
    input wire logic [3:0] phy_addr_out,
    input wire logic       strap_done_out,
    input wire logic       isolate_active_out,
    input wire logic       addr0_led0_pin_oe_out,
    input wire logic       addr1_isolate_led1_pin_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_valid_on_rise: assert property (tx_nibble_valid_out |-> $rose(tx_clk_out))
        else $error("tx valid off clock rise");
    a_idle_nibble_zero: assert property ($rose(tx_clk_out) && !tx_nibble_valid_out |-> tx_nibble_out == 4'h0)
        else $error("tx nibble not zero when idle");
    a_rx_on_fall: assert property (!$stable(rxd_out) || !$stable(rx_dv_out) |-> $fell(rx_clk_out))
        else $error("rx data moved off clock fall");
    a_take_on_fall: assert property (rx_take_out |-> $fell(rx_clk_out))
        else $error("rx take off clock fall");
    a_iso_quiet: assert property (isolate_active_out && $past(isolate_active_out) |-> !rx_dv_out && !rx_oe_out)
        else $error("rx active while isolated");
    a_addr_bit2: assert property (phy_addr_out[2] == 1'b0)
        else $error("address bit 2 not zero");
    a_addr_held: assert property (strap_done_out && $past(strap_done_out) |-> $stable(phy_addr_out))
        else $error("address changed after latch");
    a_strap_quiet: assert property (!strap_done_out |-> !addr0_led0_pin_oe_out && !addr1_isolate_led1_pin_oe_out
        && !tx_clk_out && !rx_oe_out)
        else $error("pins active during strap phase");
endmodule : pmn_mii_port_props
bind pmn_mii_port pmn_mii_port_props props_u (.*);
`default_nettype wire

// file: testbench/pmn_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmn_mac_model (
    input  wire logic       clk_in,
    input  wire logic       tx_clk_in,
    input  wire logic       rx_clk_in,
    input  wire logic       rx_dv_in,
    input  wire logic       go_in,
    output logic            tx_en_out,
    output logic [3:0]      txd_out,
    output var int          rx_count_out
);
    initial begin
        tx_en_out = 1'b0;
        txd_out = 4'h0;
        rx_count_out = 0;
    end
    always @(posedge tx_clk_in) begin
        @(negedge clk_in);
        tx_en_out = go_in && ($urandom_range(3) != 0);
        // idle data is junk, not held
        txd_out = 4'($urandom);
    end
    always @(posedge rx_clk_in) if (rx_dv_in === 1'b1) rx_count_out++;
endmodule : pmn_mac_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) chk(32'(g), 32'(e))
module testbench;
    import pmn_pkg::*;
    logic       clk_in = 0, reset_in = 1, reference_clock_input_in = 0, crystal_mode_in = 0;
    logic       speed100_in = 0, link_up_in = 0, rx_valid_in = 0, addr3_strap_in = 0;
    logic       receive_isolation_strap_in = 0, p0 = 0, p1 = 0, go = 0;
    logic [3:0] rx_nibble_in = 0, tx_nibble_out, rxd_out, phy_addr_out, txd_in;
    logic [1:0] led0_func_in = 0, led1_func_in = 0;
    logic       crystal_drive_output_out, crystal_drive_output_oe_out, tx_clk_out, tx_en_in;
    logic       tx_nibble_valid_out, rx_clk_out, rx_dv_out, rx_oe_out, rx_take_out, strap_done_out;
    logic       isolate_active_out, addr0_led0_pin_out, addr0_led0_pin_oe_out;
    logic       addr1_isolate_led1_pin_out, addr1_isolate_led1_pin_oe_out;
    int         errors = 0, checks = 0, rxc, rxe = 0;
    logic [3:0] q[$];
    // pins idle at the strap pull level
    wire logic  addr0_led0_pin_in = addr0_led0_pin_oe_out ? addr0_led0_pin_out : p0;
    wire logic  addr1_isolate_led1_pin_in = addr1_isolate_led1_pin_oe_out ? addr1_isolate_led1_pin_out : p1;

    pmn_mii_port #(.STRAP_CYCLES(8)) dut_u (.*);
    pmn_mac_model mac_u (.clk_in(clk_in), .tx_clk_in(tx_clk_out), .rx_clk_in(rx_clk_out), .rx_dv_in(rx_dv_out),
        .go_in(go), .tx_en_out(tx_en_in), .txd_out(txd_in), .rx_count_out(rxc));

    initial forever #25 clk_in = ~clk_in;
    // odd offset keeps reference unrelated in phase
    initial begin
        #7;
        forever #200 reference_clock_input_in = ~reference_clock_input_in;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge tx_clk_out) if (tx_en_in === 1'b1) q.push_back(txd_in);
    always @(negedge clk_in) if (tx_nibble_valid_out === 1'b1) begin
        if (q.size() == 0) `CMP(1, 0);
        else `CMP(tx_nibble_out, q.pop_front());
    end

    // rx source holds a valid nibble until taken; an idle source may offer a new one any cycle
    always @(negedge clk_in) begin
        if (rx_take_out === 1'b1) begin
            if (isolate_active_out === 1'b1) `CMP({rx_dv_out, rxd_out}, 5'h0);
            else begin
                `CMP(rx_dv_out, rx_valid_in);
                if (rx_valid_in) `CMP(rxd_out, rx_nibble_in);
                rxe += rx_valid_in;
            end
        end
        if (rx_take_out === 1'b1 || rx_valid_in !== 1'b1) begin
            rx_valid_in = go & 1'($urandom);
            rx_nibble_in = 4'($urandom);
        end
    end

    task automatic run_cfg(input int k);
        int  n;
        time t;
        @(negedge clk_in);
        reset_in = 1;
        speed100_in = 1'(k % 2);
        p0 = 1'($urandom);
        p1 = (k >= 2) ? 1'b1 : 1'($urandom);
        receive_isolation_strap_in = (k == 3);
        addr3_strap_in = 1'($urandom);
        crystal_mode_in = 1'($urandom);
        link_up_in = 1'($urandom);
        led0_func_in = 2'(k);
        repeat (5) @(negedge clk_in);
        reset_in = 0;
        n = 0;
        while (strap_done_out !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        `CMP(strap_done_out, 1);
        repeat (3) @(negedge clk_in);
        `CMP(phy_addr_out, {addr3_strap_in, 1'b0, p1, p0});
        `CMP(rx_oe_out, !(receive_isolation_strap_in & p1));
        `CMP(isolate_active_out, receive_isolation_strap_in & p1);
        `CMP(addr0_led0_pin_oe_out, 1);
        `CMP(addr1_isolate_led1_pin_oe_out, !receive_isolation_strap_in);
        `CMP(addr0_led0_pin_out, (k == 1) ? speed100_in : ((k == 2) ? link_up_in : 1'b0));
        if (k < 3) `CMP(addr1_isolate_led1_pin_out, speed100_in);
        `CMP(crystal_drive_output_oe_out, crystal_mode_in);
        @(posedge tx_clk_out);
        t = $time;
        @(posedge tx_clk_out);
        `CMP(($time - t) / 50, speed100_in ? 8 : 80);
        @(posedge crystal_drive_output_out);
        t = $time;
        @(posedge crystal_drive_output_out);
        `CMP(($time - t) / 50, 8);
        go = 1;
        repeat (speed100_in ? 200 : 1600) @(negedge clk_in);
        go = 0;
        repeat (speed100_in ? 40 : 300) @(negedge clk_in);
        `CMP(q.size(), 0);
        `CMP(rxc, rxe);
    endtask : run_cfg

    initial begin
        void'($urandom(32'hda64));
        for (int k = 0; k < 4; k++) run_cfg(k);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
